// file: design/external_bus_pin_mux.sv
// Purpose: routes peripheral signals onto parallel, serial and address pins
// Assumes: one clock; pin inputs are asynchronous and resynchronised
// Notes:   routing is combinational from the selection register
`timescale 1ns/10ps
`include "external_bus_pin_mux_defs.svh"

// Summary of operation
// - selection register sits at I/O port 0x1C00, read and write
// - new routing applies on the cycle after the write
// - address select bit 1 hands that address pin to its GPIO
// - address select bit 0 keeps the pin on the memory address output
// - bit 15 reads zero and ignores writes
// - bits 14:12 choose the parallel port routing
// - code 000 puts all 21 LCD bridge signals on the parallel port
// - code 001 routes SPI, six GPIO, UART and audio port two
// - code 010 routes eight LCD data bits and eight GPIO
// - code 011 routes eight LCD bits, four SPI, audio port three
// - code 100 routes eight LCD bits, audio port two, UART
// - code 101 routes eight LCD bits, four SPI, UART
// - bits 11:10 pick MMC1, audio port one plus GPIO, or GPIO
// - bits 9:8 pick MMC0, audio port zero plus GPIO, or GPIO
// - bits 5..0 steer address bits 20..15 to GPIO 26..21
module external_bus_pin_mux
  import external_bus_pin_mux_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [15:0] i_io_addr,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [15:0] i_io_wdata,
  output logic      [15:0] o_io_rdata,
  output logic             o_io_rvalid,
  input  wire logic [20:0] i_pp_pin_in,
  output logic      [20:0] o_pp_pin_out,
  output logic      [20:0] o_pp_pin_oe,
  input  wire logic [5:0]  i_sp0_pin_in,
  output logic      [5:0]  o_sp0_pin_out,
  output logic      [5:0]  o_sp0_pin_oe,
  input  wire logic [5:0]  i_sp1_pin_in,
  output logic      [5:0]  o_sp1_pin_out,
  output logic      [5:0]  o_sp1_pin_oe,
  input  wire logic [5:0]  i_addr_pin_in,
  output logic      [5:0]  o_addr_pin_out,
  output logic      [5:0]  o_addr_pin_oe,
  input  wire logic [5:0]  i_ext_mem_addr,
  input  wire logic [20:0] i_lcd_out,
  input  wire logic [20:0] i_lcd_oe,
  output logic      [20:0] o_lcd_in,
  input  wire logic [6:0]  i_spi_out,
  input  wire logic [6:0]  i_spi_oe,
  output logic      [6:0]  o_spi_in,
  input  wire logic [3:0]  i_uart_out,
  input  wire logic [3:0]  i_uart_oe,
  output logic      [3:0]  o_uart_in,
  input  wire logic [3:0]  i_i2s2_out,
  input  wire logic [3:0]  i_i2s2_oe,
  output logic      [3:0]  o_i2s2_in,
  input  wire logic [3:0]  i_i2s3_out,
  input  wire logic [3:0]  i_i2s3_oe,
  output logic      [3:0]  o_i2s3_in,
  input  wire logic [5:0]  i_mmc0_out,
  input  wire logic [5:0]  i_mmc0_oe,
  output logic      [5:0]  o_mmc0_in,
  input  wire logic [5:0]  i_mmc1_out,
  input  wire logic [5:0]  i_mmc1_oe,
  output logic      [5:0]  o_mmc1_in,
  input  wire logic [3:0]  i_i2s0_out,
  input  wire logic [3:0]  i_i2s0_oe,
  output logic      [3:0]  o_i2s0_in,
  input  wire logic [3:0]  i_i2s1_out,
  input  wire logic [3:0]  i_i2s1_oe,
  output logic      [3:0]  o_i2s1_in,
  input  wire logic [31:0] i_gpio_out,
  input  wire logic [31:0] i_gpio_oe,
  output logic      [31:0] o_gpio_in
);

  io_word_t    sel_reg;
  logic [38:0] pin_meta_reg;
  logic [38:0] pin_sync_reg;
  logic [20:0] pp_sync;
  logic [5:0]  sp0_sync;
  logic [5:0]  sp1_sync;
  logic [5:0]  addr_sync;
  pp_mode_t    pp_mode;
  sp_mode_t    sp0_mode;
  sp_mode_t    sp1_mode;
  logic [5:0]  addr_sel;
  logic        sel_hit;

  assign sel_hit  = (i_io_addr == `EBS_ADDR);
  assign pp_mode  = sel_reg[`PP_MSB:`PP_LSB];
  assign sp1_mode = sel_reg[`SP1_MSB:`SP1_LSB];
  assign sp0_mode = sel_reg[`SP0_MSB:`SP0_LSB];
  assign addr_sel = sel_reg[`ADDR_SEL_MSB:0];

  // reserved bits are masked on the way in so they can never read back set
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_reg <= `EBS_RESET;
    end else if (i_io_wr && sel_hit) begin
      sel_reg <= i_io_wdata & `EBS_WMASK;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_io_rdata  <= 16'h0000;
      o_io_rvalid <= 1'b0;
    end else begin
      o_io_rvalid <= i_io_rd && sel_hit;
      o_io_rdata  <= (i_io_rd && sel_hit) ? sel_reg : 16'h0000;
    end
  end

  // pins are asynchronous to the core; the cost is two cycles of input latency
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= {i_addr_pin_in, i_sp1_pin_in, i_sp0_pin_in, i_pp_pin_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign pp_sync   = pin_sync_reg[20:0];
  assign sp0_sync  = pin_sync_reg[26:21];
  assign sp1_sync  = pin_sync_reg[32:27];
  assign addr_sync = pin_sync_reg[38:33];

  // a peripheral that is not routed sees zero on its inputs
  always_comb begin
    o_pp_pin_out = '0;
    o_pp_pin_oe  = '0;
    o_lcd_in     = '0;
    o_spi_in     = '0;
    o_uart_in    = '0;
    o_i2s2_in    = '0;
    o_i2s3_in    = '0;
    o_sp0_pin_out = '0;
    o_sp0_pin_oe  = '0;
    o_sp1_pin_out = '0;
    o_sp1_pin_oe  = '0;
    o_mmc0_in    = '0;
    o_mmc1_in    = '0;
    o_i2s0_in    = '0;
    o_i2s1_in    = '0;
    o_gpio_in    = '0;
    case (pp_mode)
      `PP_LCD16: begin
        o_pp_pin_out = i_lcd_out;
        o_pp_pin_oe  = i_lcd_oe;
        o_lcd_in     = pp_sync;
      end
      `PP_SPI_UART: begin
        o_pp_pin_out = {i_i2s2_out, i_uart_out, i_gpio_out[29:27], i_gpio_out[20:18], i_spi_out};
        o_pp_pin_oe  = {i_i2s2_oe, i_uart_oe, i_gpio_oe[29:27], i_gpio_oe[20:18], i_spi_oe};
        o_spi_in     = pp_sync[6:0];
        {o_gpio_in[29:27], o_gpio_in[20:18]} = pp_sync[12:7];
        o_uart_in    = pp_sync[16:13];
        o_i2s2_in    = pp_sync[20:17];
      end
      `PP_LCD8_GPIO: begin
        o_pp_pin_out[15:0] = {i_gpio_out[31:27], i_gpio_out[20:18], i_lcd_out[7:0]};
        o_pp_pin_oe[15:0]  = {i_gpio_oe[31:27], i_gpio_oe[20:18], i_lcd_oe[7:0]};
        o_lcd_in[7:0]      = pp_sync[7:0];
        {o_gpio_in[31:27], o_gpio_in[20:18]} = pp_sync[15:8];
      end
      `PP_LCD8_SPI_S3: begin
        o_pp_pin_out[15:0] = {i_i2s3_out, i_spi_out[3:0], i_lcd_out[7:0]};
        o_pp_pin_oe[15:0]  = {i_i2s3_oe, i_spi_oe[3:0], i_lcd_oe[7:0]};
        o_lcd_in[7:0]      = pp_sync[7:0];
        o_spi_in[3:0]      = pp_sync[11:8];
        o_i2s3_in          = pp_sync[15:12];
      end
      `PP_LCD8_S2_UA: begin
        o_pp_pin_out[15:0] = {i_uart_out, i_i2s2_out, i_lcd_out[7:0]};
        o_pp_pin_oe[15:0]  = {i_uart_oe, i_i2s2_oe, i_lcd_oe[7:0]};
        o_lcd_in[7:0]      = pp_sync[7:0];
        o_i2s2_in          = pp_sync[11:8];
        o_uart_in          = pp_sync[15:12];
      end
      `PP_LCD8_SPI_UA: begin
        o_pp_pin_out[15:0] = {i_uart_out, i_spi_out[3:0], i_lcd_out[7:0]};
        o_pp_pin_oe[15:0]  = {i_uart_oe, i_spi_oe[3:0], i_lcd_oe[7:0]};
        o_lcd_in[7:0]      = pp_sync[7:0];
        o_spi_in[3:0]      = pp_sync[11:8];
        o_uart_in          = pp_sync[15:12];
      end
      default: begin
        o_pp_pin_oe = '0;
      end
    endcase
    case (sp0_mode)
      `SP_MMC: begin
        o_sp0_pin_out = i_mmc0_out;
        o_sp0_pin_oe  = i_mmc0_oe;
        o_mmc0_in     = sp0_sync;
      end
      `SP_I2S_GPIO: begin
        o_sp0_pin_out = {i_gpio_out[5:4], i_i2s0_out};
        o_sp0_pin_oe  = {i_gpio_oe[5:4], i_i2s0_oe};
        o_i2s0_in     = sp0_sync[3:0];
        o_gpio_in[5:4] = sp0_sync[5:4];
      end
      `SP_GPIO: begin
        o_sp0_pin_out = i_gpio_out[5:0];
        o_sp0_pin_oe  = i_gpio_oe[5:0];
        o_gpio_in[5:0] = sp0_sync;
      end
      default: begin
        o_sp0_pin_oe = '0;
      end
    endcase
    case (sp1_mode)
      `SP_MMC: begin
        o_sp1_pin_out = i_mmc1_out;
        o_sp1_pin_oe  = i_mmc1_oe;
        o_mmc1_in     = sp1_sync;
      end
      `SP_I2S_GPIO: begin
        o_sp1_pin_out = {i_gpio_out[11:10], i_i2s1_out};
        o_sp1_pin_oe  = {i_gpio_oe[11:10], i_i2s1_oe};
        o_i2s1_in     = sp1_sync[3:0];
        o_gpio_in[11:10] = sp1_sync[5:4];
      end
      `SP_GPIO: begin
        o_sp1_pin_out = i_gpio_out[11:6];
        o_sp1_pin_oe  = i_gpio_oe[11:6];
        o_gpio_in[11:6] = sp1_sync;
      end
      default: begin
        o_sp1_pin_oe = '0;
      end
    endcase
    for (int i = 0; i < `ADDR_PINS; i++) begin
      if (addr_sel[i]) begin
        o_gpio_in[`ADDR_GPIO_BASE + i] = addr_sync[i];
      end
    end
  end

  // the memory address output is always driven when it owns the pin
  always_comb begin
    for (int i = 0; i < `ADDR_PINS; i++) begin
      o_addr_pin_out[i] = addr_sel[i] ? i_gpio_out[`ADDR_GPIO_BASE + i] : i_ext_mem_addr[i];
      o_addr_pin_oe[i]  = addr_sel[i] ? i_gpio_oe[`ADDR_GPIO_BASE + i] : 1'b1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_write_read;
    (i_io_wr && sel_hit) ##1 (i_io_rd && sel_hit && !i_io_wr)
      |=> (o_io_rvalid && o_io_rdata == ($past(i_io_wdata, 2) & `EBS_WMASK));
  endproperty
  a_write_read: assert property (p_write_read) else $error("readback differs from write");

  property p_apply_next;
    (i_io_wr && sel_hit) |=> (pp_mode == $past(i_io_wdata[`PP_MSB:`PP_LSB]));
  endproperty
  a_apply_next: assert property (p_apply_next) else $error("routing not applied next cycle");

  property p_addr_gpio;
    addr_sel[0] |-> (o_addr_pin_out[0] == i_gpio_out[`ADDR_GPIO_BASE]);
  endproperty
  a_addr_gpio: assert property (p_addr_gpio) else $error("address pin 0 not on gpio");

  property p_addr_external_memory_port;
    !addr_sel[5] |-> (o_addr_pin_out[5] == i_ext_mem_addr[5] && o_addr_pin_oe[5]);
  endproperty
  a_addr_external_memory_port: assert property (p_addr_external_memory_port) else $error("address pin 5 not on memory port");

  property p_rsvd;
    !sel_reg[`EBS_RSVD_BIT] && !sel_reg[`RSVD_HI_BIT] && !sel_reg[`RSVD_LO_BIT];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

  property p_lcd16;
    (pp_mode == `PP_LCD16) |-> (o_pp_pin_out == i_lcd_out && o_lcd_in == pp_sync);
  endproperty
  a_lcd16: assert property (p_lcd16) else $error("lcd16 routing wrong");

  property p_spi_mode;
    (pp_mode == `PP_SPI_UART) |-> (o_pp_pin_out[6:0] == i_spi_out && o_uart_in == pp_sync[16:13]);
  endproperty
  a_spi_mode: assert property (p_spi_mode) else $error("spi mode routing wrong");

  property p_lcd8_uart;
    (pp_mode == `PP_LCD8_SPI_UA) |-> (o_pp_pin_out[15:12] == i_uart_out && o_pp_pin_oe[20:16] == 5'h00);
  endproperty
  a_lcd8_uart: assert property (p_lcd8_uart) else $error("lcd8 uart routing wrong");

  property p_pp_rsvd;
    (pp_mode > `PP_LCD8_SPI_UA) |-> (o_pp_pin_oe == '0);
  endproperty
  a_pp_rsvd: assert property (p_pp_rsvd) else $error("reserved mode drives pins");

  property p_sp1_mmc;
    (sp1_mode == `SP_MMC) |-> (o_sp1_pin_out == i_mmc1_out && o_mmc1_in == sp1_sync);
  endproperty
  a_sp1_mmc: assert property (p_sp1_mmc) else $error("serial port 1 mmc routing wrong");

  property p_sp0_gpio;
    (sp0_mode == `SP_GPIO) |-> (o_sp0_pin_out == i_gpio_out[5:0] && o_gpio_in[5:0] == sp0_sync);
  endproperty
  a_sp0_gpio: assert property (p_sp0_gpio) else $error("serial port 0 gpio routing wrong");

  c_write: cover property ((i_io_wr && sel_hit) ##1 (i_io_rd && sel_hit));
  c_pp_change: cover property ((pp_mode == `PP_LCD16) ##1 (pp_mode == `PP_LCD8_GPIO));
  c_addr_gpio: cover property (addr_sel == 6'h3F);
  c_sp_rsvd: cover property (sp0_mode == 2'h3);

endmodule // external_bus_pin_mux

// file: design/external_bus_pin_mux_defs.svh
// Purpose: constants for the external bus pin multiplexer
// Assumes: 16-bit I/O port data path
// Notes:   the reset value is a plain default
`ifndef EXTERNAL_BUS_PIN_MUX_DEFS_SVH
`define EXTERNAL_BUS_PIN_MUX_DEFS_SVH
`define EBS_ADDR       16'h1C00
`define EBS_WMASK      16'h7F3F
`define EBS_RESET      16'h0000
`define EBS_RSVD_BIT   15
`define PP_MSB         14
`define PP_LSB         12
`define SP1_MSB        11
`define SP1_LSB        10
`define SP0_MSB        9
`define SP0_LSB        8
`define RSVD_HI_BIT    7
`define RSVD_LO_BIT    6
`define ADDR_SEL_MSB   5
`define PP_LCD16       3'h0
`define PP_SPI_UART    3'h1
`define PP_LCD8_GPIO   3'h2
`define PP_LCD8_SPI_S3 3'h3
`define PP_LCD8_S2_UA  3'h4
`define PP_LCD8_SPI_UA 3'h5
`define SP_MMC         2'h0
`define SP_I2S_GPIO    2'h1
`define SP_GPIO        2'h2
`define ADDR_GPIO_BASE 21
`define PP_PINS        21
`define SP_PINS        6
`define ADDR_PINS      6
`endif

// file: design/external_bus_pin_mux_pkg.sv
// Purpose: types for the external bus pin multiplexer
// Assumes: constants come from the defs header
// Notes:   mode fields are kept as raw codes
package external_bus_pin_mux_pkg;
  typedef logic [2:0]  pp_mode_t;
  typedef logic [1:0]  sp_mode_t;
  typedef logic [15:0] io_word_t;
endpackage

// file: tb/periph_pin_model.sv
// Purpose: peripheral controllers and package pins facing the mux
// Assumes: the bench offers each new set of output and pin values
// Notes:   a gated peripheral freezes its outputs; a soft reset clears them
`timescale 1ns/10ps
module periph_pin_model #(
  parameter int W = 229
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_gate,
  input  wire logic         i_soft_rst,
  input  wire logic [W-1:0] i_next,
  output logic      [W-1:0] o_sig
);
  // only a soft reset moves the outputs while gated, so a half-rerouted bus never sees a live edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sig <= '0;
    end else if (i_soft_rst) begin
      o_sig <= '0;
    end else if (!i_gate) begin
      o_sig <= i_next;
    end
  end
endmodule // periph_pin_model

// file: tb/test_external_bus_pin_mux.sv
// Purpose: self-checking bench for the external bus pin multiplexer
// Assumes: 50 MHz clock, registered read answer one cycle after the strobe
// Notes:   peripheral and pin values are random from a fixed seed
`timescale 1ns/10ps
`include "external_bus_pin_mux_defs.svh"
module test_external_bus_pin_mux
  import external_bus_pin_mux_pkg::*;
;
  logic         i_clk, i_rst, wr, rd, gate, srst, rv;
  logic [15:0]  addr, rdat;
  io_word_t     wdat, exp_reg, v;
  logic [228:0] nxt, sig;
  logic [255:0] raw;
  logic [20:0]  ppo, ppe;
  logic [5:0]   s0o, s0e, s1o, s1e, ao, ae;
  int           mismatches, cmp_count, seed, k;
  wire  [31:0]  go = sig[151:120];
  wire  [31:0]  ge = sig[183:152];
  wire  [5:0]   ema = sig[228:223];
  wire  [91:0]  pin_in;

  periph_pin_model #(.W(229)) model (.i_clk(i_clk), .i_rst(i_rst), .i_gate(gate), .i_soft_rst(srst),
    .i_next(nxt), .o_sig(sig));
  external_bus_pin_mux dut (.i_clk(i_clk), .i_rst(i_rst), .i_io_addr(addr), .i_io_wr(wr), .i_io_rd(rd),
    .i_io_wdata(wdat), .o_io_rdata(rdat), .o_io_rvalid(rv), .i_pp_pin_in(sig[204:184]),
    .o_pp_pin_out(ppo), .o_pp_pin_oe(ppe), .i_sp0_pin_in(sig[210:205]), .o_sp0_pin_out(s0o),
    .o_sp0_pin_oe(s0e), .i_sp1_pin_in(sig[216:211]), .o_sp1_pin_out(s1o), .o_sp1_pin_oe(s1e),
    .i_addr_pin_in(sig[222:217]), .o_addr_pin_out(ao), .o_addr_pin_oe(ae), .i_ext_mem_addr(ema),
    .i_lcd_out(sig[20:0]), .i_lcd_oe(sig[41:21]), .o_lcd_in(pin_in[20:0]), .i_spi_out(sig[48:42]),
    .i_spi_oe(sig[55:49]), .o_spi_in(pin_in[27:21]), .i_uart_out(sig[59:56]), .i_uart_oe(sig[63:60]),
    .o_uart_in(pin_in[31:28]), .i_i2s2_out(sig[67:64]), .i_i2s2_oe(sig[71:68]), .o_i2s2_in(pin_in[35:32]),
    .i_i2s3_out(sig[75:72]), .i_i2s3_oe(sig[79:76]), .o_i2s3_in(pin_in[39:36]), .i_mmc0_out(sig[85:80]),
    .i_mmc0_oe(sig[91:86]), .o_mmc0_in(pin_in[45:40]), .i_mmc1_out(sig[97:92]), .i_mmc1_oe(sig[103:98]),
    .o_mmc1_in(pin_in[51:46]), .i_i2s0_out(sig[107:104]), .i_i2s0_oe(sig[111:108]), .o_i2s0_in(pin_in[55:52]),
    .i_i2s1_out(sig[115:112]), .i_i2s1_oe(sig[119:116]), .o_i2s1_in(pin_in[59:56]), .i_gpio_out(go),
    .i_gpio_oe(ge), .o_gpio_in(pin_in[91:60]));

  always #10 i_clk = ~i_clk;

  function automatic logic [20:0] pp_map(input logic [2:0] m, input logic [20:0] l, input logic [6:0] s,
    input logic [3:0] u, input logic [3:0] a2, input logic [3:0] a3, input logic [31:0] g);
    case (m)
      3'h0: return l;
      3'h1: return {a2, u, g[29:27], g[20:18], s};
      3'h2: return {5'h00, g[31:27], g[20:18], l[7:0]};
      3'h3: return {5'h00, a3, s[3:0], l[7:0]};
      3'h4: return {5'h00, u, a2, l[7:0]};
      3'h5: return {5'h00, u, s[3:0], l[7:0]};
      default: return 21'h00_0000;
    endcase
  endfunction

  function automatic logic [5:0] sp_map(input logic [1:0] m, input logic [5:0] mmc, input logic [3:0] i2s,
    input logic [5:0] g);
    case (m)
      2'h0: return mmc;
      2'h1: return {g[5:4], i2s};
      2'h2: return g;
      default: return 6'h00;
    endcase
  endfunction

  // what each peripheral should see from the synchronised pins; unrouted inputs read zero
  function automatic logic [91:0] in_map(input io_word_t r, input logic [20:0] p, input logic [5:0] z0,
    input logic [5:0] z1, input logic [5:0] ap);
    logic [20:0] l;
    logic [6:0]  s;
    logic [3:0]  u, a2, a3, i0, i1;
    logic [5:0]  m0, m1;
    logic [31:0] g;
    {l, s, u, a2, a3, i0, i1, m0, m1, g} = '0;
    case (r[14:12])
      3'h0: l = p;
      3'h1: {a2, u, g[29:27], g[20:18], s} = p;
      3'h2: {g[31:27], g[20:18], l[7:0]} = p[15:0];
      3'h3: {a3, s[3:0], l[7:0]} = p[15:0];
      3'h4: {u, a2, l[7:0]} = p[15:0];
      3'h5: {u, s[3:0], l[7:0]} = p[15:0];
      default: l = 21'h00_0000;
    endcase
    case (r[9:8])
      2'h0: m0 = z0;
      2'h1: {g[5:4], i0} = z0;
      2'h2: g[5:0] = z0;
      default: m0 = 6'h00;
    endcase
    case (r[11:10])
      2'h0: m1 = z1;
      2'h1: {g[11:10], i1} = z1;
      2'h2: g[11:6] = z1;
      default: m1 = 6'h00;
    endcase
    for (int i = 0; i < 6; i++) begin
      if (r[i]) g[21+i] = ap[i];
    end
    return {g, i1, i0, m1, m0, a3, a2, u, s, l};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input io_word_t d);
    @(posedge i_clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic ev, input io_word_t ed);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    @(negedge i_clk);
    chk({rv, rdat}, {ev, ed});
  endtask

  task automatic check_pins;
    logic [5:0]  eo, eoe;
    logic [91:0] ein;
    for (int i = 0; i < 6; i++) begin
      eo[i] = exp_reg[i] ? go[21+i] : ema[i];
      eoe[i] = exp_reg[i] ? ge[21+i] : 1'b1;
    end
    chk(ppo, pp_map(exp_reg[14:12], sig[20:0], sig[48:42], sig[59:56],
      sig[67:64], sig[75:72], go));
    chk(ppe, pp_map(exp_reg[14:12], sig[41:21], sig[55:49], sig[63:60],
      sig[71:68], sig[79:76], ge));
    chk({s1o, s0o}, {sp_map(exp_reg[11:10], sig[97:92], sig[115:112], go[11:6]),
      sp_map(exp_reg[9:8], sig[85:80], sig[107:104], go[5:0])});
    chk({s1e, s0e}, {sp_map(exp_reg[11:10], sig[103:98], sig[119:116], ge[11:6]),
      sp_map(exp_reg[9:8], sig[91:86], sig[111:108], ge[5:0])});
    chk({ae, ao}, {eoe, eo});
    ein = in_map(exp_reg, sig[204:184], sig[210:205], sig[216:211], sig[222:217]);
    chk(pin_in[31:0], ein[31:0]);
    chk(pin_in[63:32], ein[63:32]);
    chk({4'h0, pin_in[91:64]}, {4'h0, ein[91:64]});
  endtask

  task automatic test_done;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    seed = 32'h0000_effa;
    {i_clk, wr, rd, gate, srst} = '0;
    i_rst = 1'b1;
    {addr, wdat, nxt, mismatches, cmp_count} = '0;
    exp_reg = `EBS_RESET;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_chk(`EBS_ADDR, 1'b1, exp_reg);
    // a neighbouring address must neither answer nor disturb the register
    wr_reg(16'h1C01, 16'hFFFF);
    rd_chk(16'h1C01, 1'b0, 16'h0000);
    rd_chk(`EBS_ADDR, 1'b1, exp_reg);
    // write then read on the very next edge, reserved bits written as ones
    @(posedge i_clk);
    addr <= `EBS_ADDR;
    wdat <= 16'hFFFF;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    exp_reg = 16'hFFFF & `EBS_WMASK;
    @(negedge i_clk);
    chk({rv, rdat}, {1'b1, exp_reg});
    for (k = 0; k < 48; k++) begin
      v = 16'($random(seed));
      if (k < 8) begin
        v[14:12] = k[2:0];
        v[11:8] = {k[1:0], ~k[1:0]};
        v[5:0] = k[0] ? 6'h3F : 6'h00;
      end
      @(posedge i_clk);
      gate <= 1'b1;
      exp_reg = v & `EBS_WMASK;
      wr_reg(`EBS_ADDR, v);
      @(negedge i_clk);
      check_pins();
      @(posedge i_clk);
      srst <= 1'b1;
      @(posedge i_clk);
      srst <= 1'b0;
      gate <= 1'b0;
      rd_chk(`EBS_ADDR, 1'b1, exp_reg);
      repeat (3) begin
        for (int i = 0; i < 8; i++) raw[i*32+:32] = $random(seed);
        @(posedge i_clk);
        nxt <= raw[228:0];
        // one edge for the model to take the values, two more for the pin synchroniser
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        check_pins();
      end
    end
    test_done();
  end
endmodule // test_external_bus_pin_mux
